//--- rtl/mtog_top.sv
// motor thermal overload guard: content model, alarm, lockout, inputs
`timescale 1ns/1ps
module mtog_top #(
    parameter int TICK_CYCLES = mtog_pkg::TICK_CYCLES
) (
    input  wire logic                 CLK,
    input  wire logic                 RST,
    input  wire logic [7:0]           DIN,            // discrete input terminals
    input  wire mtog_pkg::mtog_func_e DIN_FUNC [8],   // per-input function
    input  wire logic [15:0]          CURRENT,        // measured amps
    input  wire logic [15:0]          FULL_LOAD_CURRENT,
    input  wire logic [7:0]           SERVICE_FACTOR,  // hundredths
    input  wire logic [7:0]           DERATE_FACTOR,   // hundredths, >=100
    input  wire mtog_pkg::mtog_phase_e PHASE,          // motor operating phase
    input  wire logic                 START_CMD,      // start command pulse
    input  wire logic                 RUN_CMD,        // run command level
    input  wire logic [5:0]           RUN_CLASS,      // 0 = off, 1..40
    input  wire logic [5:0]           START_CLASS,    // 0 = off, 1..40
    input  wire logic                 INDEP_CLASSES,  // separate start/run class
    input  wire logic [6:0]           HOT_COLD_RATIO, // 0..99 percent
    input  wire logic [13:0]          COOL_TIME,      // tenths of minutes
    input  wire logic [6:0]           ALARM_LEVEL,    // 1..100 percent
    input  wire logic [6:0]           LOCK_LEVEL,     // 1..99 percent
    input  wire logic                 AUTO_RELEASE_LEVEL_MODE,
    input  wire logic [9:0]           DIN_TRIP_TIME,  // tenths of seconds
    input  wire logic [7:0]           SPEED_TRIP_TIME,// seconds, 0 = off
    output logic [6:0]                CONTENT_PCT,    // content, whole percent
    output logic                      OL_ALARM,       // alarm, relay follower
    output logic                      OL_TRIP,        // overload tripped
    output logic                      LOCKOUT,        // restart blocked
    output logic [6:0]                RELEASE_LEVEL,  // active release level
    output logic                      DIN_FAULT,      // digital input fault
    output logic                      STALL_FAULT,    // zero speed stall
    output mtog_pkg::mtog_func_s      FUNCS           // decoded input functions
);
    localparam int CW = mtog_pkg::CW;

    // tick divider
    logic [$clog2(TICK_CYCLES+1)-1:0] div_q;  // cycle counter
    logic                             tick_q; // one-cycle slow enable
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            div_q  <= '0;
            tick_q <= 1'b0;
        end else if (div_q == $bits(div_q)'(TICK_CYCLES - 1)) begin
            div_q  <= '0;
            tick_q <= 1'b1;
        end else begin
            div_q  <= div_q + 1'b1;
            tick_q <= 1'b0;
        end
    end

    // input decoding
    mtog_pkg::mtog_func_s func;  // decoded functions
    mtog_input_decode #(.N(mtog_pkg::NIN)) u_dec (
        .clk    (CLK),
        .rst    (RST),
        .din    (DIN),
        .cfg    (DIN_FUNC),
        .func_q (func)
    );
    assign FUNCS = func;

    // active class choice
    logic       starting;   // kick or ramp phase
    logic [5:0] act_class;  // class in force now
    assign starting  = (PHASE == mtog_pkg::PH_KICK) || (PHASE == mtog_pkg::PH_RAMP);
    assign act_class = (INDEP_CLASSES && starting) ? START_CLASS : RUN_CLASS;

    // steady state target in fixed point percent
    logic [CW+15:0] tgt_num;   // ratio * current, scaled
    logic [CW-1:0]  target;    // steady target content
    logic [31:0]    over_lim;  // full load times service factor
    logic           overload;  // current above full load * sf
    always_comb begin
        tgt_num  = '0;
        target   = '0;
        over_lim = 32'(FULL_LOAD_CURRENT) * 32'(SERVICE_FACTOR);
        overload = (32'(CURRENT) * 32'd100) > over_lim;
        if (FULL_LOAD_CURRENT != '0 && DERATE_FACTOR != '0) begin
            tgt_num = ((40'(HOT_COLD_RATIO) << mtog_pkg::FRAC) * 40'(CURRENT) * 40'd100)
                      / (40'(FULL_LOAD_CURRENT) * 40'(DERATE_FACTOR));
            target  = (tgt_num > 40'(mtog_pkg::FULL_CONTENT)) ?
                      mtog_pkg::FULL_CONTENT : tgt_num[CW-1:0];
        end
    end

    // exponential step: per tick, content moves by diff*5*tick/cool_time
    logic [CW-1:0]  content_q;  // accumulated content
    logic [CW-1:0]  diff;       // distance to goal
    logic [CW+15:0] step;       // step this tick
    logic [CW-1:0]  goal;       // target or zero when stopped
    logic [CW-1:0]  heat_step;  // overload heating per tick
    logic           stopped;    // motor not running
    logic           accum_on;   // class allows accumulation
    assign stopped  = (PHASE == mtog_pkg::PH_STOPPED);
    assign accum_on = (act_class != 6'h00) && overload;
    assign goal     = stopped ? '0 : target;
    // heating rate grows with current and falls with class
    assign heat_step = (act_class == 6'h00) ? '0 :
                       CW'((32'(CURRENT) << 8) / (32'(FULL_LOAD_CURRENT) | 32'd1)
                           * 32'd64 / 32'(act_class));
    // cooling time held inside its legal range, so a zero never divides
    logic [13:0]    cool_t;     // clamped cooling time, tenths of minutes
    assign cool_t = (COOL_TIME < mtog_pkg::COOL_MIN) ? mtog_pkg::COOL_MIN :
                    (COOL_TIME > mtog_pkg::COOL_MAX) ? mtog_pkg::COOL_MAX :
                    COOL_TIME;
    always_comb begin
        diff = (content_q > goal) ? content_q - goal : goal - content_q;
        // tick period 0.1 s, cool time in tenths of minutes: 5*0.1/(ct*6)
        step = (40'(diff) * 40'd5) / (40'(cool_t) * 40'd60);
        if (step == '0 && diff != '0) step = 40'd1;
    end

    // content update
    logic trip_q;  // overload tripped, held until released
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            content_q <= '0;
        end else if (func.thermal_clr && trip_q) begin
            content_q <= '0;
        end else if (INDEP_CLASSES && RUN_CLASS == '0 && START_CLASS == '0) begin
            content_q <= '0;   // both classes off under separate classes erase content
        end else if (tick_q) begin
            if (accum_on && !stopped) begin
                content_q <= (content_q + heat_step > mtog_pkg::FULL_CONTENT ||
                              content_q + heat_step < content_q) ?
                             mtog_pkg::FULL_CONTENT : content_q + heat_step;
            end else if (content_q > goal) begin
                content_q <= (CW'(step) > content_q) ? '0 : content_q - CW'(step);
            end else begin
                content_q <= content_q + CW'(step);
            end
        end
    end
    assign CONTENT_PCT = content_q[CW-2:mtog_pkg::FRAC];

    // alarm follows content against alarm level
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) OL_ALARM <= 1'b0;
        else     OL_ALARM <= (CONTENT_PCT >= ALARM_LEVEL) && (ALARM_LEVEL != '0);
    end

    // start history
    logic [6:0] hist_q [mtog_pkg::HIST];  // consumed per start
    logic [6:0] start_pct_q;              // content latched at start
    logic       start_live_q;             // a start is in progress
    logic [1:0] hist_n_q;                 // valid entries minus one
    logic       hist_any_q;               // history holds any entry
    mtog_pkg::mtog_phase_e phase_q;        // previous phase
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            start_pct_q  <= '0;
            start_live_q <= 1'b0;
            hist_n_q     <= '0;
            hist_any_q   <= 1'b0;
            phase_q      <= mtog_pkg::PH_STOPPED;
            for (int i = 0; i < mtog_pkg::HIST; i++) hist_q[i] <= '0;
        end else begin
            phase_q <= PHASE;
            if (START_CMD) begin
                start_pct_q  <= CONTENT_PCT;
                start_live_q <= 1'b1;
            end else if (start_live_q && PHASE == mtog_pkg::PH_AT_SPEED
                         && phase_q != mtog_pkg::PH_AT_SPEED) begin
                start_live_q <= 1'b0;
                hist_q[0]    <= (CONTENT_PCT > start_pct_q) ? CONTENT_PCT - start_pct_q : '0;
                for (int i = 1; i < mtog_pkg::HIST; i++) hist_q[i] <= hist_q[i-1];
                if (hist_any_q && hist_n_q != 2'h3) hist_n_q <= hist_n_q + 2'h1;
                hist_any_q <= 1'b1;
            end else if (stopped) begin
                start_live_q <= 1'b0;   // aborted start not recorded
            end
        end
    end

    // automatic release level
    logic [8:0] sum;       // history sum
    logic [8:0] avg;       // integer average
    logic [9:0] margin;    // average times 1.25
    logic [6:0] auto_lvl;  // computed release level
    always_comb begin
        sum = '0;
        for (int i = 0; i < mtog_pkg::HIST; i++)
            if (3'(i) <= {1'b0, hist_n_q}) sum = sum + 9'(hist_q[i]);
        avg      = hist_any_q ? sum / 9'({1'b0, hist_n_q} + 3'h1) : '0;
        margin   = 10'(avg) + 10'(avg >> 2);
        auto_lvl = (margin >= 10'd100) ? 7'h00 : 7'(10'd100 - margin);
    end
    assign RELEASE_LEVEL = AUTO_RELEASE_LEVEL_MODE ? auto_lvl : LOCK_LEVEL;

    // trip and lockout
    logic run_trip;  // content reached full
    assign run_trip = (content_q >= mtog_pkg::FULL_CONTENT) && (act_class != '0);
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            trip_q <= 1'b0;
        end else if (run_trip) begin
            trip_q <= 1'b1;   // set wins over clear
        end else if (func.thermal_clr || (trip_q && stopped && CONTENT_PCT < RELEASE_LEVEL)) begin
            trip_q <= 1'b0;
        end
    end
    assign OL_TRIP = trip_q;
    // auto mode can hold lockout before a trip when headroom is short
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) LOCKOUT <= 1'b0;
        else     LOCKOUT <= trip_q || (AUTO_RELEASE_LEVEL_MODE && stopped && hist_any_q
                                       && CONTENT_PCT >= auto_lvl);
    end

    // digital input fault timer, tenths of seconds = one tick each
    logic din_exp;  // fault level persisted
    mtog_tick_timer #(.W(10)) u_dtrip (
        .clk       (CLK),
        .rst       (RST),
        .tick      (tick_q),
        .cond      (func.fault_hi),
        .limit     (DIN_TRIP_TIME),
        .expired_q (din_exp)
    );
    // fault latch, fault reset input clears it
    always_ff @(posedge CLK or posedge RST) begin
        if (RST)               DIN_FAULT <= 1'b0;
        else if (din_exp)      DIN_FAULT <= 1'b1;
        else if (func.fault_reset) DIN_FAULT <= 1'b0;
    end

    // zero speed stall timer, seconds = ten ticks each
    logic        spd_exp;   // stall detected
    logic [11:0] spd_lim;   // limit in ticks
    assign spd_lim = 12'(SPEED_TRIP_TIME) * 12'd10;
    mtog_tick_timer #(.W(12)) u_spd (
        .clk       (CLK),
        .rst       (RST),
        .tick      (tick_q),
        .cond      (RUN_CMD && func.zero_speed),
        .limit     (spd_lim),
        .expired_q (spd_exp)
    );
    always_ff @(posedge CLK or posedge RST) begin
        if (RST)               STALL_FAULT <= 1'b0;
        else if (spd_exp)      STALL_FAULT <= 1'b1;
        else if (func.fault_reset) STALL_FAULT <= 1'b0;
    end

    // assertions
    content_cap_a: assert property (@(posedge CLK) disable iff (RST)
        content_q <= mtog_pkg::FULL_CONTENT) else $error("content above full");
    trip_lock_a: assert property (@(posedge CLK) disable iff (RST)
        trip_q |-> ##1 LOCKOUT) else $error("trip without lockout");
    alarm_level_a: assert property (@(posedge CLK) disable iff (RST)
        (ALARM_LEVEL != '0 && CONTENT_PCT >= ALARM_LEVEL) |=> OL_ALARM)
        else $error("alarm missed");
    clr_content_a: assert property (@(posedge CLK) disable iff (RST)
        (func.thermal_clr && trip_q) |=> content_q == '0) else $error("clear failed");
    release_calc_a: assert property (@(posedge CLK) disable iff (RST)
        !AUTO_RELEASE_LEVEL_MODE |-> RELEASE_LEVEL == LOCK_LEVEL) else $error("level");
    stopped_fall_a: assert property (@(posedge CLK) disable iff (RST)
        (stopped && tick_q && !(func.thermal_clr && trip_q)) |=>
        content_q <= $past(content_q)) else $error("content rose while stopped");
    tick_period_a: assert property (@(posedge CLK) disable iff (RST)
        tick_q |=> !tick_q) else $error("tick too long");
    stall_flag_a: assert property (@(posedge CLK) disable iff (RST)
        spd_exp |=> STALL_FAULT) else $error("stall missed");

    // steps of a finished start, a cooled trip and short headroom
    sequence start_done_s;
        start_live_q && !START_CMD && PHASE == mtog_pkg::PH_AT_SPEED
            && phase_q != mtog_pkg::PH_AT_SPEED;
    endsequence
    sequence cooled_s;
        trip_q && !run_trip && stopped && CONTENT_PCT < RELEASE_LEVEL;
    endsequence
    sequence auto_short_s;
        AUTO_RELEASE_LEVEL_MODE && stopped && hist_any_q && CONTENT_PCT >= auto_lvl;
    endsequence

    // start reaching speed leaves an entry
    hist_record_a: assert property (@(posedge CLK) disable iff (RST)
        start_done_s
        |=> hist_any_q && !start_live_q)
        else $error("start not recorded");

    // cooled below release level frees the trip
    trip_release_a: assert property (@(posedge CLK) disable iff (RST)
        cooled_s
        |=> !trip_q)
        else $error("trip held after cooling");

    // trip holds while the motor is not stopped
    trip_hold_a: assert property (@(posedge CLK) disable iff (RST)
        (trip_q && !func.thermal_clr && !stopped)
        |=> trip_q)
        else $error("trip dropped early");

    // class off never raises a trip
    class_off_a: assert property (@(posedge CLK) disable iff (RST)
        (act_class == '0 && !trip_q)
        |=> !trip_q)
        else $error("trip with class off");

    // short headroom locks out without a trip
    auto_lock_a: assert property (@(posedge CLK) disable iff (RST)
        auto_short_s
        |=> LOCKOUT)
        else $error("auto lockout missed");

    // expired input timer latches the fault
    din_trip_a: assert property (@(posedge CLK) disable iff (RST)
        din_exp
        |=> DIN_FAULT)
        else $error("input fault missed");

    // fault reset clears a settled input fault
    din_clear_a: assert property (@(posedge CLK) disable iff (RST)
        (func.fault_reset && !din_exp)
        |=> !DIN_FAULT)
        else $error("input fault not reset");

    // fault reset clears a settled stall
    stall_clear_a: assert property (@(posedge CLK) disable iff (RST)
        (func.fault_reset && !spd_exp)
        |=> !STALL_FAULT)
        else $error("stall not reset");

    // alarm drops below its level
    alarm_clear_a: assert property (@(posedge CLK) disable iff (RST)
        (CONTENT_PCT < ALARM_LEVEL)
        |=> !OL_ALARM)
        else $error("alarm stuck");

    // both classes off under separate classes erase the content
    erase_both_a: assert property (@(posedge CLK) disable iff (RST)
        (INDEP_CLASSES && RUN_CLASS == '0 && START_CLASS == '0)
        |=> content_q == '0)
        else $error("content not erased");

    // fixed level mode locks only on a trip
    lock_free_a: assert property (@(posedge CLK) disable iff (RST)
        (!trip_q && !AUTO_RELEASE_LEVEL_MODE)
        |=> !LOCKOUT)
        else $error("lockout without trip");
endmodule

//--- rtl/mtog_pkg.sv
// package of constants and carrier types for the motor thermal overload guard
package mtog_pkg;
    // content fixed point: percent with 16 fraction bits
    localparam int CW          = 24;
    localparam int FRAC        = 16;
    localparam logic [CW-1:0] FULL_CONTENT = 24'h640000; // 100 percent
    // timing
    localparam int CLK_HZ      = 250_000_000;
    localparam int TICK_MS     = 100;                // model tick, ms
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    // defaults
    localparam logic [5:0]  CLASS_DEF   = 6'h0a;     // class 10
    localparam logic [6:0]  RATIO_DEF   = 7'h3c;     // 60 percent
    localparam logic [13:0] COOL_DEF    = 14'h012c;  // 30.0 min in tenths
    localparam logic [13:0] COOL_MIN    = 14'h000a;  // 1.0 min
    localparam logic [13:0] COOL_MAX    = 14'h270f;  // 999.9 min
    localparam logic [6:0]  ALARM_DEF   = 7'h5a;     // 90 percent
    localparam logic [6:0]  LOCK_DEF    = 7'h0f;     // 15 percent
    localparam logic [9:0]  DTRIP_DEF   = 10'h001;   // 0.1 s in tenths
    localparam logic [7:0]  SPD_DEF     = 8'h00;     // off
    localparam int          NIN         = 8;
    localparam int          HIST        = 4;
    // input functions
    typedef enum logic [4:0] {
        FN_OFF, FN_STOP, FN_FAULT_HI, FN_FAULT_LO, FN_FAULT_RST, FN_DISCONNECT,
        FN_INLINE, FN_BYPASS, FN_THERMAL_CLR, FN_LOC_REM, FN_HEAT_DIS,
        FN_HEAT_EN, FN_RAMP2, FN_SLOW_FWD, FN_SLOW_REV, FN_BRAKE_DIS,
        FN_BRAKE_EN, FN_ZS_LOW, FN_ZS_HIGH
    } mtog_func_e;
    // motor operating phase
    typedef enum logic [2:0] {
        PH_STOPPED, PH_KICK, PH_RAMP, PH_AT_SPEED, PH_STOPPING
    } mtog_phase_e;
    // decoded input functions
    typedef struct packed {
        logic stop_cmd;
        logic fault_hi;
        logic fault_reset;
        logic disconnect;
        logic inline_fb;
        logic bypass_fb;
        logic thermal_clr;
        logic remote_sel;
        logic heat_dis;
        logic heat_en;
        logic ramp2;
        logic slow_fwd;
        logic slow_rev;
        logic brake_dis;
        logic brake_en;
        logic zero_speed;
    } mtog_func_s;
endpackage

//--- rtl/mtog_input_decode.sv
// synchroniser and function decoder for the eight discrete inputs
`timescale 1ns/1ps
module mtog_input_decode #(
    parameter int N = mtog_pkg::NIN
) (
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic [N-1:0]           din,      // raw terminals
    input  wire mtog_pkg::mtog_func_e   cfg [N],  // per-input function
    output mtog_pkg::mtog_func_s        func_q    // decoded functions
);
    logic [N-1:0] s1_q;   // first sync stage
    logic [N-1:0] s2_q;   // second sync stage

    // two flop synchroniser per input
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
        end
    end

    // function decode, one or of all inputs per function
    mtog_pkg::mtog_func_s func_d;
    always_comb begin
        func_d = '0;
        for (int i = 0; i < N; i++) begin
            case (cfg[i])
                mtog_pkg::FN_STOP:        func_d.stop_cmd    |= s2_q[i];
                mtog_pkg::FN_FAULT_HI:    func_d.fault_hi    |= s2_q[i];
                mtog_pkg::FN_FAULT_LO:    func_d.fault_hi    |= ~s2_q[i];
                mtog_pkg::FN_FAULT_RST:   func_d.fault_reset |= s2_q[i];
                mtog_pkg::FN_DISCONNECT:  func_d.disconnect  |= s2_q[i];
                mtog_pkg::FN_INLINE:      func_d.inline_fb   |= s2_q[i];
                mtog_pkg::FN_BYPASS:      func_d.bypass_fb   |= s2_q[i];
                mtog_pkg::FN_THERMAL_CLR: func_d.thermal_clr |= s2_q[i];
                mtog_pkg::FN_LOC_REM:     func_d.remote_sel  |= s2_q[i];
                mtog_pkg::FN_HEAT_DIS:    func_d.heat_dis    |= s2_q[i];
                mtog_pkg::FN_HEAT_EN:     func_d.heat_en     |= s2_q[i];
                mtog_pkg::FN_RAMP2:       func_d.ramp2       |= s2_q[i];
                mtog_pkg::FN_SLOW_FWD:    func_d.slow_fwd    |= s2_q[i];
                mtog_pkg::FN_SLOW_REV:    func_d.slow_rev    |= s2_q[i];
                mtog_pkg::FN_BRAKE_DIS:   func_d.brake_dis   |= s2_q[i];
                mtog_pkg::FN_BRAKE_EN:    func_d.brake_en    |= s2_q[i];
                mtog_pkg::FN_ZS_LOW:      func_d.zero_speed  |= ~s2_q[i];
                mtog_pkg::FN_ZS_HIGH:     func_d.zero_speed  |= s2_q[i];
                default:                  ;                                   // no function
            endcase
        end
    end

    // registered function outputs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) func_q <= '0;
        else     func_q <= func_d;
    end
endmodule

//--- rtl/mtog_tick_timer.sv
// persistence timer counting model ticks while a condition holds
`timescale 1ns/1ps
module mtog_tick_timer #(
    parameter int W = 12
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         tick,     // slow-rate enable pulse
    input  wire logic         cond,     // condition being timed
    input  wire logic [W-1:0] limit,    // ticks required, zero disables
    output logic              expired_q // condition persisted long enough
);
    logic [W-1:0] cnt_q;   // elapsed ticks

    // count while condition holds, clear when it drops
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q     <= '0;
            expired_q <= 1'b0;
        end else if (!cond || limit == '0) begin
            cnt_q     <= '0;
            expired_q <= 1'b0;
        end else if (tick) begin
            if (cnt_q + W'(1) >= limit) expired_q <= 1'b1;
            else                        cnt_q     <= cnt_q + W'(1);
        end
    end
endmodule

//--- tb/mtog_far_side.sv
// far side model: terminal levels and measured motor current
`timescale 1ns/1ps
module mtog_far_side (
    input  wire logic        clk,  // system clock
    output logic [7:0]       din,  // terminal levels
    output logic [15:0]      amps  // measured current
);
    // terminals open, motor at rest
    initial begin
        din  = 8'h00;
        amps = 16'h0000;
    end
    // change levels only after a falling edge
    task automatic drive(input logic [7:0] d, input logic [15:0] a);
        @(negedge clk);
        din  <= d;
        amps <= a;
    endtask
endmodule

//--- tb/testbench.sv
// self-checking bench for the motor thermal overload guard
`timescale 1ns/1ps
module testbench;
    localparam int TK = 20;  // short tick for simulation
    logic clk = 1'b0, rst = 1'b1;
    logic [7:0] din;
    logic [15:0] amps;
    mtog_pkg::mtog_func_e fn [8];
    mtog_pkg::mtog_phase_e ph = mtog_pkg::PH_STOPPED;
    logic [5:0] rcl = 6'h00;
    logic [13:0] cool = 14'h000a;  // 1.0 min, fastest cooling
    logic [9:0] dtrip = 10'h002;    // two ticks
    logic aut = 1'b0;
    logic scmd = 1'b0, rcmd = 1'b0, indep = 1'b0;
    logic [6:0] lockl = mtog_pkg::LOCK_DEF;
    logic [7:0] spdt = 8'h00;
    logic [6:0] pct, rel;
    logic alm, trp, lck, dfl, stl;
    mtog_pkg::mtog_func_s funcs;
    int miscompares = 0, checked = 0, n;
    // free-running clock, 4 ns period
    always #2 clk = ~clk;
    mtog_far_side far (.clk(clk), .din(din), .amps(amps));
    mtog_top #(.TICK_CYCLES(TK)) DUT (.CLK(clk), .RST(rst), .DIN(din), .DIN_FUNC(fn),
        .CURRENT(amps), .FULL_LOAD_CURRENT(16'h0064), .SERVICE_FACTOR(8'h73),
        .DERATE_FACTOR(8'h64), .PHASE(ph), .START_CMD(scmd), .RUN_CMD(rcmd),
        .RUN_CLASS(rcl), .START_CLASS(rcl), .INDEP_CLASSES(indep),
        .HOT_COLD_RATIO(7'h3c), .COOL_TIME(cool), .ALARM_LEVEL(7'h5a),
        .LOCK_LEVEL(lockl), .AUTO_RELEASE_LEVEL_MODE(aut), .DIN_TRIP_TIME(dtrip),
        .SPEED_TRIP_TIME(spdt), .CONTENT_PCT(pct), .OL_ALARM(alm), .OL_TRIP(trp),
        .LOCKOUT(lck), .RELEASE_LEVEL(rel), .DIN_FAULT(dfl), .STALL_FAULT(stl),
        .FUNCS(funcs));
    // compare one value and count the outcome
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            miscompares++;
            $display("MISMATCH %s exp %h got %h", nm, e, s);
        end
    endtask
    // wait whole cycles on the falling edge
    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask
    // heat at eight times full load until the trip latches
    task automatic heat();
        ph = mtog_pkg::PH_AT_SPEED;
        far.drive(8'h00, 16'h0320);
        n = 0;
        while (trp !== 1'b1 && n < 300 * TK) begin
            cyc(1);
            n++;
        end
        cyc(1);  // lockout register follows the trip one cycle later
    endtask
    // print the counts and the verdict, then stop
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // watchdog against a hang
    initial begin
        #(60000 * 4);
        miscompares++;
        give_verdict();
    end
    initial begin
        fn = '{mtog_pkg::FN_STOP, mtog_pkg::FN_FAULT_RST, mtog_pkg::FN_THERMAL_CLR,
               mtog_pkg::FN_LOC_REM, mtog_pkg::FN_RAMP2, mtog_pkg::FN_SLOW_FWD,
               mtog_pkg::FN_BRAKE_EN, mtog_pkg::FN_ZS_LOW};
        cyc(2);
        rst = 1'b0;
        cyc(1);
        chk("content", pct, 0);
        chk("release", rel, 15);
        // first function table, terminals high then low
        far.drive(8'hff, 16'h0000);
        cyc(4);
        chk("funcs_a_hi", funcs, 32'ha332);
        far.drive(8'h00, 16'h0000);
        cyc(4);
        chk("funcs_a_lo", funcs, 32'h0001);
        fn = '{mtog_pkg::FN_HEAT_DIS, mtog_pkg::FN_HEAT_EN, mtog_pkg::FN_SLOW_REV,
               mtog_pkg::FN_BRAKE_DIS, mtog_pkg::FN_DISCONNECT, mtog_pkg::FN_INLINE,
               mtog_pkg::FN_BYPASS, mtog_pkg::FN_ZS_HIGH};
        far.drive(8'hff, 16'h0000);
        cyc(4);
        chk("funcs_b_hi", funcs, 32'h1ccd);
        // fault-high input must persist the trip time
        fn = '{default: mtog_pkg::FN_OFF};
        fn[0] = mtog_pkg::FN_FAULT_HI;
        fn[1] = mtog_pkg::FN_FAULT_RST;
        fn[2] = mtog_pkg::FN_THERMAL_CLR;
        far.drive(8'h01, 16'h0000);
        n = 0;
        while (dfl !== 1'b1 && n < 6 * TK) begin
            cyc(1);
            n++;
        end
        chk("din_delay", (n >= TK) && (n <= 3 * TK + 8), 1);
        far.drive(8'h00, 16'h0000);
        cyc(4);
        chk("din_latch", dfl, 1);
        far.drive(8'h02, 16'h0000);
        cyc(6);
        chk("din_reset", dfl, 0);
        fn[0] = mtog_pkg::FN_FAULT_LO;
        far.drive(8'h00, 16'h0000);
        cyc(4 * TK);
        chk("din_low", dfl, 1);
        // zero speed held while running flags a stall after the trip time
        fn[3] = mtog_pkg::FN_ZS_HIGH;
        rcmd = 1'b1;
        spdt = 8'h01;
        far.drive(8'h08, 16'h0000);
        cyc(150);
        chk("stall_early", stl, 0);
        cyc(80);
        chk("stall", stl, 1);
        rcmd = 1'b0;
        // class off: overcurrent at speed never trips
        heat();
        chk("off_trip", trp, 0);
        rcl = 6'h01;
        heat();
        chk("trip", trp, 1);
        chk("full", pct, 100);
        chk("alarm", alm, 1);
        chk("lockout", lck, 1);
        // emergency clear after a trip empties the content
        ph = mtog_pkg::PH_STOPPED;
        far.drive(8'h04, 16'h0000);
        cyc(6);
        chk("eclear", {trp, pct}, 0);
        heat();
        // stopped: exponential cooling to the lockout level
        ph = mtog_pkg::PH_STOPPED;
        far.drive(8'h00, 16'h0000);
        n = 0;
        while (lck !== 1'b0 && n < 700 * TK) begin
            cyc(1);
            n++;
        end
        chk("cool_time", (n >= 190 * TK) && (n <= 270 * TK), 1);
        chk("below_lock", pct < 7'h0f, 1);
        chk("alarm_off", alm, 0);
        // half load at speed settles at ratio times load
        ph = mtog_pkg::PH_AT_SPEED;
        rcl = 6'h0a;
        far.drive(8'h00, 16'h0032);
        cyc(600 * TK);
        chk("steady", (pct >= 28) && (pct <= 30), 1);
        aut = 1'b1;
        cyc(2);
        chk("auto_rel", rel, 100);
        // a start reaching speed enters the history: about 20 percent used
        ph = mtog_pkg::PH_RAMP;
        rcl = 6'h01;
        scmd = 1'b1;
        far.drive(8'h00, 16'h0320);
        scmd = 1'b0;
        cyc(10 * TK);
        ph = mtog_pkg::PH_AT_SPEED;
        cyc(2);
        chk("auto_hist", (rel >= 73) && (rel <= 77), 1);
        // both classes off under separate classes erase the content
        indep = 1'b1;
        rcl = 6'h00;
        cyc(2);
        chk("erase", pct, 0);
        give_verdict();
    end
endmodule
